// ---- swt_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module swt_top (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic external_slow_clock_in,
    input wire logic sync_detect_in,
    input wire logic tx_fifo_write_in,
    output logic sleep_state_out,
    output logic rx_on_out,
    output logic tx_on_out,
    output logic rc_osc_run_out,
    output logic tx_accept_irq_out
);

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic [7:0] prescale_reg;
    logic [7:0] interval_hi_reg;
    logic [7:0] interval_lo_reg;
    logic [7:0] stay_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    swt_pkg::swt_state_t state_reg;
    swt_pkg::swt_state_t state_next;
    logic [15:0] wake_cnt_reg;
    logic [15:0] wake_cnt_next;
    logic [7:0] stay_cnt_reg;
    logic [7:0] stay_cnt_next;
    logic oneshot_done_reg;
    logic oneshot_done_next;
    logic pend_reg;
    logic pend_next;
    logic irq_reg;
    logic irq_next;
    logic rx_on_reg;
    logic rx_on_next;
    logic tx_on_reg;
    logic tx_on_next;
    logic rc_run_reg;
    logic wake_run;
    logic slow_tick;
    logic wake_tick;
    logic stay_tick;

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    wire wr_ctrl = reg_wr_in & (reg_addr_in == swt_pkg::ADDR_CTRL);
    wire wr_prescale = reg_wr_in & (reg_addr_in == swt_pkg::ADDR_PRESCALE);
    wire wr_int_hi = reg_wr_in & (reg_addr_in == swt_pkg::ADDR_INTERVAL_HI);
    wire wr_int_lo = reg_wr_in & (reg_addr_in == swt_pkg::ADDR_INTERVAL_LO);
    wire wr_stay = reg_wr_in & (reg_addr_in == swt_pkg::ADDR_STAY);
    wire wr_interval = wr_int_hi | wr_int_lo;

    // ----------------------------------------
    // Control fields
    // ----------------------------------------
    wire single_shot_select = ctrl_reg[swt_pkg::BIT_SINGLE_SHOT];
    wire post_wake_state_select = ctrl_reg[swt_pkg::BIT_POST_WAKE_TX];
    wire stay_awake_timer_enable = ctrl_reg[swt_pkg::BIT_STAY_EN];
    wire auto_wake_enable = ctrl_reg[swt_pkg::BIT_AUTO_WAKE];
    wire rc_osc_sleep_only = ctrl_reg[swt_pkg::BIT_RC_SLEEP_ONLY];
    wire wake_clock_source_select = ctrl_reg[swt_pkg::BIT_CLK_SRC_RC];
    wire [3:0] wake_prescale = prescale_reg[3:0];
    wire [3:0] stay_awake_prescale = prescale_reg[7:4];
    wire [15:0] wake_interval_value = {interval_hi_reg, interval_lo_reg};
    wire [7:0] stay_awake_value = stay_reg;
    wire host_sleep = reg_wdata_in[swt_pkg::BIT_SLEEP];

    wire asleep = (state_reg == swt_pkg::SWT_ASLEEP);
    wire woken = (state_reg == swt_pkg::SWT_WOKEN);
    wire rc_run_next = ~rc_osc_sleep_only | (state_next == swt_pkg::SWT_ASLEEP);

    // ----------------------------------------
    // Timer clocking
    // ----------------------------------------
    swt_slow_tick u_slow_tick (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .external_slow_clock_in(external_slow_clock_in),
        .rc_select_in(wake_clock_source_select),
        .rc_run_in(rc_run_reg),
        .tick_out(slow_tick)
    );

    swt_prescaler u_wake_prescaler (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .tick_in(slow_tick),
        .code_in(wake_prescale),
        .clear_in(~wake_run | wr_interval),
        .tick_out(wake_tick)
    );

    swt_prescaler u_stay_prescaler (
        .ref_clk_in(ref_clk_in),
        .resetn_in(resetn_in),
        .tick_in(slow_tick),
        .code_in(stay_awake_prescale),
        .clear_in(~woken),
        .tick_out(stay_tick)
    );

    // ----------------------------------------
    // Wake timer
    // ----------------------------------------
    assign wake_run = auto_wake_enable & ~oneshot_done_reg;
    // Reload takes the byte being written, not the stale one
    wire [15:0] wake_load_value = {(wr_int_hi ? reg_wdata_in : interval_hi_reg),
                                   (wr_int_lo ? reg_wdata_in : interval_lo_reg)};
    wire wake_zero = (wake_cnt_reg == 16'h0000);
    wire wake_expire = wake_run & wake_tick & wake_zero;

    assign wake_cnt_next = (!wake_run || wr_interval) ? wake_load_value :
                           (!wake_tick) ? wake_cnt_reg :
                           wake_zero ? wake_interval_value :
                           wake_cnt_reg - 16'h0001;

    // Set on expiry wins over a control write in the same cycle
    assign oneshot_done_next = (wake_expire & single_shot_select) |
                               (oneshot_done_reg & ~wr_ctrl);

    // ----------------------------------------
    // Stay-awake timer
    // ----------------------------------------
    wire stay_zero = (stay_cnt_reg == 8'h00);
    wire stay_expire = woken & stay_tick & stay_zero;

    assign stay_cnt_next = (!woken) ? stay_awake_value :
                           (stay_tick && !stay_zero) ? stay_cnt_reg - 8'h01 :
                           stay_cnt_reg;

    // ----------------------------------------
    // Sleep state machine
    // ----------------------------------------
    wire auto_wake = asleep & wake_expire & auto_wake_enable;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            swt_pkg::SWT_AWAKE:
            begin
                if (wr_ctrl && host_sleep)
                begin
                    state_next = swt_pkg::SWT_ASLEEP;
                end
            end
            swt_pkg::SWT_ASLEEP:
            begin
                if (wr_ctrl && !host_sleep)
                begin
                    state_next = swt_pkg::SWT_AWAKE;
                end
                else if (auto_wake && !wr_ctrl)
                begin
                    if (stay_awake_timer_enable)
                    begin
                        state_next = swt_pkg::SWT_WOKEN;
                    end
                    else
                    begin
                        state_next = swt_pkg::SWT_AWAKE;
                    end
                end
            end
            swt_pkg::SWT_WOKEN:
            begin
                if (wr_ctrl)
                begin
                    state_next = host_sleep ? swt_pkg::SWT_ASLEEP : swt_pkg::SWT_AWAKE;
                end
                else if (stay_expire)
                begin
                    state_next = swt_pkg::SWT_ASLEEP;
                end
                else if (sync_detect_in && !post_wake_state_select)
                begin
                    state_next = swt_pkg::SWT_AWAKE;
                end
            end
            default:
            begin
                state_next = swt_pkg::SWT_AWAKE;
            end
        endcase
    end

    // ----------------------------------------
    // Radio state after wake
    // ----------------------------------------
    wire to_sleep = (state_next == swt_pkg::SWT_ASLEEP);
    wire to_normal = asleep & ~to_sleep & (~auto_wake | wr_ctrl);

    assign rx_on_next = ~to_sleep & ~to_normal &
                        (auto_wake ? ~post_wake_state_select : rx_on_reg);
    assign tx_on_next = ~to_sleep & ~to_normal &
                        (auto_wake ? post_wake_state_select : tx_on_reg);

    // ----------------------------------------
    // Transmit accept interrupt
    // ----------------------------------------
    assign pend_next = asleep & (pend_reg | tx_fifo_write_in);
    assign irq_next = ~asleep & (pend_reg | tx_fifo_write_in);

    // ----------------------------------------
    // Register writes and reads
    // ----------------------------------------
    assign ctrl_next = {(wr_ctrl ? reg_wdata_in[7:1] : ctrl_reg[7:1]), to_sleep};

    assign rdata_next = (reg_addr_in == swt_pkg::ADDR_CTRL) ? ctrl_reg :
                        (reg_addr_in == swt_pkg::ADDR_PRESCALE) ? prescale_reg :
                        (reg_addr_in == swt_pkg::ADDR_INTERVAL_HI) ? interval_hi_reg :
                        (reg_addr_in == swt_pkg::ADDR_INTERVAL_LO) ? interval_lo_reg :
                        (reg_addr_in == swt_pkg::ADDR_STAY) ? stay_reg :
                        8'h00;

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ctrl_reg <= swt_pkg::CTRL_RESET;
            prescale_reg <= swt_pkg::PRESCALE_RESET;
            interval_hi_reg <= swt_pkg::INTERVAL_RESET;
            interval_lo_reg <= swt_pkg::INTERVAL_RESET;
            stay_reg <= swt_pkg::STAY_RESET;
            rdata_reg <= 8'h00;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            if (wr_prescale)
            begin
                prescale_reg <= reg_wdata_in;
            end
            if (wr_int_hi)
            begin
                interval_hi_reg <= reg_wdata_in;
            end
            if (wr_int_lo)
            begin
                interval_lo_reg <= reg_wdata_in;
            end
            if (wr_stay)
            begin
                stay_reg <= reg_wdata_in;
            end
            if (reg_rd_in)
            begin
                rdata_reg <= rdata_next;
            end
        end
    end

    // ----------------------------------------
    // Timer and state flops
    // ----------------------------------------
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state_reg <= swt_pkg::SWT_AWAKE;
            wake_cnt_reg <= 16'h0000;
            stay_cnt_reg <= 8'h00;
            oneshot_done_reg <= 1'b0;
            pend_reg <= 1'b0;
            irq_reg <= 1'b0;
            rx_on_reg <= 1'b0;
            tx_on_reg <= 1'b0;
            rc_run_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            wake_cnt_reg <= wake_cnt_next;
            stay_cnt_reg <= stay_cnt_next;
            oneshot_done_reg <= oneshot_done_next;
            pend_reg <= pend_next;
            irq_reg <= irq_next;
            rx_on_reg <= rx_on_next;
            tx_on_reg <= tx_on_next;
            rc_run_reg <= rc_run_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata_out = rdata_reg;
    assign sleep_state_out = ctrl_reg[swt_pkg::BIT_SLEEP];
    assign rx_on_out = rx_on_reg;
    assign tx_on_out = tx_on_reg;
    assign rc_osc_run_out = rc_run_reg;
    assign tx_accept_irq_out = irq_reg;

endmodule
`default_nettype wire

// ---- swt_pkg.sv ----
// Function
// - Control bit 7 set: wake timer stops after one expiry; clear: repeats.
// - Control bit 6 picks post-wake radio state: zero receive, one transmit.
// - Stay-awake timer expiry after a wake-up returns device to sleep.
// - Transmit FIFO write during sleep raises accept interrupt only after waking.
// - Control bit 5 set starts stay-awake timer at each automatic wake-up.
// - Control bit 4 enables automatic wake at wake timer expiry.
// - Control bit 3, reset one: RC oscillator always on, or only asleep.
// - Control bit 2 picks timer clock: external slow pin or RC oscillator.
// - Control bit 0 written one enters sleep, zero returns to normal.
// - Divider bits 7:4 give stay-awake prescale: none, 128 up to 16384.
// - Divider bits 3:0 give wake prescale: none, 128 up to 16384.
// - Wake interval is clock period times prescale times interval plus one.
// - Interval lower byte sits in its own register after the upper byte.
// - Stay-awake period is clock period times prescale times value plus one.
`default_nettype none
package swt_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h2d;
    localparam logic [7:0] ADDR_PRESCALE = 8'h2e;
    localparam logic [7:0] ADDR_INTERVAL_HI = 8'h2f;
    localparam logic [7:0] ADDR_INTERVAL_LO = 8'h30;
    localparam logic [7:0] ADDR_STAY = 8'h31;

    localparam logic [7:0] CTRL_RESET = 8'h08;
    localparam logic [7:0] PRESCALE_RESET = 8'h00;
    localparam logic [7:0] INTERVAL_RESET = 8'h00;
    localparam logic [7:0] STAY_RESET = 8'h00;

    // ----------------------------------------
    // Control fields
    // ----------------------------------------
    localparam int BIT_SINGLE_SHOT = 7;
    localparam int BIT_POST_WAKE_TX = 6;
    localparam int BIT_STAY_EN = 5;
    localparam int BIT_AUTO_WAKE = 4;
    localparam int BIT_RC_SLEEP_ONLY = 3;
    localparam int BIT_CLK_SRC_RC = 2;
    localparam int BIT_SLEEP = 0;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_FREQ_HZ = 25_000_000;
    localparam int RC_FREQ_HZ = 32_768;
    localparam int RC_DIV_CYCLES = CLK_FREQ_HZ / RC_FREQ_HZ;
    localparam int RC_CNT_W = 10;
    localparam logic [RC_CNT_W-1:0] RC_LAST = RC_CNT_W'(RC_DIV_CYCLES - 1);
    localparam int PRESCALE_W = 14;

    typedef enum logic [1:0] {
        SWT_AWAKE,
        SWT_ASLEEP,
        SWT_WOKEN
    } swt_state_t;

    // Terminal count of a prescaler for a divider code
    function automatic logic [PRESCALE_W-1:0] prescale_last(input logic [3:0] code);
        logic [PRESCALE_W-1:0] last;
        last = 14'h3fff;
        case (code)
            4'h0: last = 14'h0000;
            4'h1: last = 14'h007f;
            4'h2: last = 14'h00ff;
            4'h3: last = 14'h01ff;
            4'h4: last = 14'h03ff;
            4'h5: last = 14'h07ff;
            4'h6: last = 14'h0fff;
            4'h7: last = 14'h1fff;
            default: last = 14'h3fff;
        endcase
        return last;
    endfunction

endpackage
`default_nettype wire

// ---- swt_slow_tick.sv ----
`timescale 1ns/10ps
`default_nettype none
module swt_slow_tick (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic external_slow_clock_in,
    input wire logic rc_select_in,
    input wire logic rc_run_in,
    output logic tick_out
);

    logic ext_prev_reg;
    logic [swt_pkg::RC_CNT_W-1:0] rc_cnt_reg;
    logic [swt_pkg::RC_CNT_W-1:0] rc_cnt_next;
    logic tick_reg;
    wire ext_rise = external_slow_clock_in & ~ext_prev_reg;
    wire rc_hit = rc_run_in & (rc_cnt_reg == swt_pkg::RC_LAST);
    wire tick_next = rc_select_in ? rc_hit : ext_rise;

    // ----------------------------------------
    // RC oscillator model, stopped when idle
    // ----------------------------------------
    assign rc_cnt_next = (!rc_run_in || rc_hit) ? '0 : rc_cnt_reg + 1'b1;

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ext_prev_reg <= 1'b0;
            rc_cnt_reg <= '0;
            tick_reg <= 1'b0;
        end
        else
        begin
            ext_prev_reg <= external_slow_clock_in;
            rc_cnt_reg <= rc_cnt_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_out = tick_reg;

endmodule
`default_nettype wire

// ---- swt_prescaler.sv ----
`timescale 1ns/10ps
`default_nettype none
module swt_prescaler (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic tick_in,
    input wire logic [3:0] code_in,
    input wire logic clear_in,
    output logic tick_out
);

    logic [swt_pkg::PRESCALE_W-1:0] cnt_reg;
    logic [swt_pkg::PRESCALE_W-1:0] cnt_next;
    wire [swt_pkg::PRESCALE_W-1:0] last = swt_pkg::prescale_last(code_in);
    wire hit = tick_in & (cnt_reg >= last);

    // ----------------------------------------
    // Divide slow ticks by the coded factor
    // ----------------------------------------
    assign cnt_next = clear_in ? '0 : (hit ? '0 : (tick_in ? cnt_reg + 1'b1 : cnt_reg));
    assign tick_out = hit & ~clear_in;

    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            cnt_reg <= '0;
        end
        else
        begin
            cnt_reg <= cnt_next;
        end
    end

endmodule
`default_nettype wire

// ---- swt_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module swt_sva (
    input wire logic ref_clk_in,
    input wire logic resetn_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic external_slow_clock_in,
    input wire logic sync_detect_in,
    input wire logic tx_fifo_write_in,
    input wire logic sleep_state_out,
    input wire logic rx_on_out,
    input wire logic tx_on_out,
    input wire logic rc_osc_run_out,
    input wire logic tx_accept_irq_out
);
    // ----------------------------------------
    // Shadow of control writes
    // ----------------------------------------
    logic [7:0] ctrl_reg;
    wire logic ctrl_write = reg_wr_in && (reg_addr_in == swt_pkg::ADDR_CTRL);
    wire logic addr_mapped = (reg_addr_in >= swt_pkg::ADDR_CTRL) &&
        (reg_addr_in <= swt_pkg::ADDR_STAY);
    always_ff @(posedge ref_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            ctrl_reg <= swt_pkg::CTRL_RESET;
        else if (ctrl_write)
            ctrl_reg <= reg_wdata_in;
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!resetn_in);

    sleep_write_a: assert property (ctrl_write |=> sleep_state_out == $past(reg_wdata_in[0]))
        else $error("sleep state does not follow control write");
    unmapped_read_a: assert property (reg_rd_in && !addr_mapped |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    wake_state_a: assert property ($fell(sleep_state_out) && !$past(ctrl_write) |->
        tx_on_out == ctrl_reg[6] && rx_on_out == !ctrl_reg[6])
        else $error("wrong radio state after wake");
    auto_wake_en_a: assert property ($fell(sleep_state_out) && !$past(ctrl_write) |-> ctrl_reg[4])
        else $error("wake without enable");
    leave_sleep_a: assert property (sleep_state_out && !ctrl_write |=>
        sleep_state_out || rx_on_out || tx_on_out)
        else $error("left sleep without radio state");
    asleep_quiet_a: assert property (sleep_state_out |-> !rx_on_out && !tx_on_out)
        else $error("radio on while asleep");
    irq_awake_a: assert property (tx_fifo_write_in && !sleep_state_out |=> tx_accept_irq_out)
        else $error("missing accept pulse");
    irq_after_sleep_a: assert property (tx_accept_irq_out |-> !$past(sleep_state_out))
        else $error("accept pulse during sleep");
    rc_run_a: assert property ((sleep_state_out && $past(sleep_state_out)) ||
        (!ctrl_reg[3] && !$past(ctrl_reg[3])) |-> rc_osc_run_out)
        else $error("oscillator stopped");
    rc_stop_a: assert property (!sleep_state_out && !$past(sleep_state_out) && ctrl_reg[3] &&
        $past(ctrl_reg[3]) |-> !rc_osc_run_out)
        else $error("oscillator runs while awake");
endmodule

bind swt_top swt_sva i_swt_sva (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .external_slow_clock_in(external_slow_clock_in), .sync_detect_in(sync_detect_in),
    .tx_fifo_write_in(tx_fifo_write_in), .sleep_state_out(sleep_state_out),
    .rx_on_out(rx_on_out), .tx_on_out(tx_on_out), .rc_osc_run_out(rc_osc_run_out),
    .tx_accept_irq_out(tx_accept_irq_out));
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic ref_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic external_slow_clock_in = 1'b0;
    logic sync_detect_in = 1'b0;
    logic tx_fifo_write_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic sleep_state_out, rx_on_out, tx_on_out, rc_osc_run_out, tx_accept_irq_out;
    int errors = 0;
    int total_checks = 0;
    int irq_count = 0;
    logic [31:0] seed = 32'h0001_3420;

    swt_top i_dut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .external_slow_clock_in(external_slow_clock_in),
        .sync_detect_in(sync_detect_in), .tx_fifo_write_in(tx_fifo_write_in),
        .sleep_state_out(sleep_state_out), .rx_on_out(rx_on_out), .tx_on_out(tx_on_out),
        .rc_osc_run_out(rc_osc_run_out), .tx_accept_irq_out(tx_accept_irq_out));

    // ----------------------------------------
    // Clock, monitor and helpers
    // ----------------------------------------
    initial
    begin
        forever #20 ref_clk_in = ~ref_clk_in;
    end

    always @(posedge ref_clk_in)
        if (tx_accept_irq_out === 1'b1)
            irq_count++;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic int wake_ticks(input logic [3:0] code, input int n);
        int f;
        f = (code == 4'h0) ? 1 : ((code > 4'h7) ? 16384 : (64 << code));
        return f * (n + 1);
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        @(negedge ref_clk_in);
        check(reg_rdata_out, exp, "read data");
    endtask

    task automatic slow(input int n);
        repeat (n)
        begin
            repeat (8) @(posedge ref_clk_in);
            external_slow_clock_in <= 1'b1;
            repeat (8) @(posedge ref_clk_in);
            external_slow_clock_in <= 1'b0;
        end
        repeat (10) @(negedge ref_clk_in);
    endtask

    task automatic pulse_fifo();
        @(posedge ref_clk_in);
        tx_fifo_write_in <= 1'b1;
        @(posedge ref_clk_in);
        tx_fifo_write_in <= 1'b0;
        repeat (3) @(negedge ref_clk_in);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (60000) @(posedge ref_clk_in);
        errors++;
        $display("BAD %0t watchdog expired", $time);
        final_report();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        logic [7:0] v;
        int n, c, k, base;
        repeat (20) @(posedge ref_clk_in);
        resetn_in <= 1'b1;
        rd(swt_pkg::ADDR_CTRL, swt_pkg::CTRL_RESET);
        check(rc_osc_run_out, 1'b0, "rc runs while awake");
        for (k = 0; k < 4; k++)
            rd(8'(swt_pkg::ADDR_PRESCALE + k), 8'h00);
        for (k = 0; k < 5; k++)
        begin
            v = 8'(rnd());
            if (k == 0)
                v = v & 8'hee;
            wr(8'(swt_pkg::ADDR_CTRL + k), v);
            rd(8'(swt_pkg::ADDR_CTRL + k), v);
        end
        wr(8'h32, 8'h5a);
        rd(8'h32, 8'h00);
        rd(8'h2c, 8'h00);
        $display("test registers done");
        wr(swt_pkg::ADDR_CTRL, 8'h01);
        @(negedge ref_clk_in);
        check(sleep_state_out, 1'b1, "no sleep");
        rd(swt_pkg::ADDR_CTRL, 8'h01);
        wr(swt_pkg::ADDR_CTRL, 8'h00);
        @(negedge ref_clk_in);
        check(sleep_state_out, 1'b0, "no return");
        base = irq_count;
        pulse_fifo();
        check(8'(irq_count - base), 8'h01, "irq awake");
        $display("test sleep control done");
        for (c = 0; c < 4; c++)
        begin
            n = (c < 2) ? 2 + int'(rnd() % 4) : 2;
            wr(swt_pkg::ADDR_PRESCALE, {4'h0, 4'(c / 2)});
            wr(swt_pkg::ADDR_CTRL, {1'b0, c[0], 6'h11});
            wr(swt_pkg::ADDR_INTERVAL_HI, 8'h00);
            wr(swt_pkg::ADDR_INTERVAL_LO, 8'(n));
            base = irq_count;
            pulse_fifo();
            check(8'(irq_count - base), 8'h00, "irq while asleep");
            slow(wake_ticks(4'(c / 2), n) - 1);
            check(sleep_state_out, 1'b1, "woke early");
            slow(1);
            check(sleep_state_out, 1'b0, "no wake");
            check(tx_on_out, c[0], "tx state");
            check(rx_on_out, !c[0], "rx state");
            check(rc_osc_run_out, 1'b1, "rc not continuous");
            check(8'(irq_count - base), 8'h01, "irq after wake");
            slow(2);
            check(sleep_state_out, 1'b0, "slept without stay timer");
        end
        $display("test wake interval done");
        wr(swt_pkg::ADDR_PRESCALE, 8'h00);
        wr(swt_pkg::ADDR_STAY, 8'h01);
        for (k = 0; k < 3; k++)
        begin
            wr(swt_pkg::ADDR_CTRL, (k == 1) ? 8'hb1 : 8'h31);
            wr(swt_pkg::ADDR_INTERVAL_HI, 8'h00);
            wr(swt_pkg::ADDR_INTERVAL_LO, 8'h03);
            slow(4);
            check(rx_on_out, 1'b1, "rx after wake");
            if (k == 2)
            begin
                @(posedge ref_clk_in);
                sync_detect_in <= 1'b1;
                @(posedge ref_clk_in);
                sync_detect_in <= 1'b0;
            end
            slow(2);
            check(sleep_state_out, (k == 2) ? 1'b0 : 1'b1, "stay timer");
            slow(2);
            check(sleep_state_out, (k == 1) ? 1'b1 : 1'b0, "rewake");
        end
        $display("test stay awake done");
        wr(swt_pkg::ADDR_CTRL, 8'h00);
        wr(swt_pkg::ADDR_INTERVAL_LO, 8'h02);
        wr(swt_pkg::ADDR_CTRL, 8'h15);
        n = 0;
        @(negedge ref_clk_in);
        while (sleep_state_out === 1'b1 && n < 3000)
        begin
            @(negedge ref_clk_in);
            n++;
        end
        check(8'(n > 1500 && n < 2300), 8'h01, "rc wake time");
        $display("test rc source done");
        final_report();
    end
endmodule
`default_nettype wire
